// ---- i2c_master_model.sv ----
`timescale 1ns/1ns
module i2c_master_model (
    input wire logic clock, // System clock
    input wire logic sdaLine, // Data wire level
    output logic scl, // Serial clock drive
    output logic sda, // Data drive, one releases
    output logic ackSeen, // Last sampled acknowledge
    output logic ackToggle // Flips on each acknowledge
);
    // Idle bus
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        ackSeen = 1'b0;
        ackToggle = 1'b0;
    end
    // Ten system clocks per bus phase
    task automatic tick();
        repeat (10) @(posedge clock);
        #5;
    endtask
    // One clock pulse, wire sampled while high
    task automatic pulse();
        tick();
        scl = 1'b1;
        tick();
        ackSeen = !sdaLine;
        scl = 1'b0;
        tick();
    endtask
    // Start, also used as repeated Start
    task automatic startCond();
        sda = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda = 1'b0;
        tick();
        scl = 1'b0;
        tick();
    endtask
    task automatic stopCond();
        sda = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda = 1'b1;
        tick();
    endtask
    // Byte MSB first, then release for the acknowledge
    task automatic sendByte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda = b[i];
            pulse();
        end
        sda = 1'b1;
        pulse();
        ackToggle = ~ackToggle;
    endtask
endmodule

// ---- nv_config_monitor.sv ----
`timescale 1ns/1ns
module nv_config_monitor
    import nv_config_pkg::*;
#(
    parameter int PROG_CYCLES = 20
) (
    input wire logic clock, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic deviceResetReq, // Copy request
    input wire logic nvProgramBusyFlag, // Busy
    input wire logic [1:0] cfgResolutionSel, // Working resolution
    input wire logic [1:0] cfgFaultQueueSel, // Working queue
    input wire logic cfgShutdown, // Working shutdown
    input wire logic [3:0] resolutionBits, // Decoded bits
    input wire logic [7:0] conversionTimeMs, // Decoded time
    input wire logic [2:0] faultsRequired, // Decoded faults
    input wire logic registersLocked, // Lock view
    input wire logic permanentLockdown, // Lockdown view
    input wire logic [15:0] nvConfigView // Store view
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    int busyLen;
    int sinceReq;
    // Busy length and cycles since a copy request
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busyLen <= 0;
            sinceReq <= 99;
        end else begin
            busyLen <= nvProgramBusyFlag ? busyLen + 1 : 0;
            sinceReq <= deviceResetReq ? 0 : (sinceReq < 99 ? sinceReq + 1 : 99);
        end
    end
    property p_reserved_zero;
        (nvConfigView & ~NV_WRITE_MASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
    property p_lock_flags;
        registersLocked == (nvConfigView[LOCK_BIT] | nvConfigView[LOCKDOWN_BIT])
            && permanentLockdown == nvConfigView[LOCKDOWN_BIT];
    endproperty
    a_lock_flags: assert property (p_lock_flags) else $error("lock flags wrong");
    property p_lockdown_sticky;
        permanentLockdown |=> permanentLockdown;
    endproperty
    a_lockdown_sticky: assert property (p_lockdown_sticky) else $error("lockdown cleared");
    property p_store_at_end;
        $changed(nvConfigView) |-> $fell(nvProgramBusyFlag);
    endproperty
    a_store_at_end: assert property (p_store_at_end) else $error("store changed early");
    property p_busy_span;
        $fell(nvProgramBusyFlag) |-> busyLen >= PROG_CYCLES && busyLen <= PROG_CYCLES + 1;
    endproperty
    a_busy_span: assert property (p_busy_span) else $error("busy span wrong");
    property p_res_decode;
        $stable(cfgResolutionSel)[*2] |-> resolutionBits == RES_BITS_BASE + {2'h0, cfgResolutionSel}
            && conversionTimeMs == (CONV_TIME_BASE_MS << cfgResolutionSel);
    endproperty
    a_res_decode: assert property (p_res_decode) else $error("resolution decode wrong");
    property p_fault_decode;
        $stable(cfgFaultQueueSel)[*2] |->
            faultsRequired == (cfgFaultQueueSel == 2'h0 ? FAULTS_CODE0 : {cfgFaultQueueSel, 1'b0});
    endproperty
    a_fault_decode: assert property (p_fault_decode) else $error("fault decode wrong");
    property p_copy_on_request;
        $changed({cfgResolutionSel, cfgFaultQueueSel, cfgShutdown}) |-> sinceReq < 12;
    endproperty
    a_copy_on_request: assert property (p_copy_on_request) else $error("config changed alone");
endmodule

// ---- nv_config_pkg.sv ----
package nv_config_pkg;
    // Bus framing
    localparam logic [3:0] ADDR_FIXED = 4'h9;
    localparam logic [7:0] PTR_NV_CONFIG = 8'h11;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] BYTE_ADDR = 3'h0;
    localparam logic [2:0] BYTE_PTR = 3'h1;
    localparam logic [2:0] BYTE_HI = 3'h2;
    localparam logic [2:0] BYTE_LO = 3'h3;
    localparam logic [2:0] BYTE_EXTRA = 3'h4;

    // Field layout of the store
    localparam int LOCK_BIT = 1;
    localparam int LOCKDOWN_BIT = 2;
    localparam int SD_BIT = 8;
    localparam int MODE_BIT = 9;
    localparam int POL_BIT = 10;
    localparam int FQ_LSB = 11;
    localparam int RES_LSB = 13;
    localparam logic [15:0] NV_FACTORY = 16'h0000;
    localparam logic [15:0] NV_WRITE_MASK = 16'h7F06;

    // Decode tables
    localparam logic [3:0] RES_BITS_BASE = 4'h9;
    localparam logic [7:0] CONV_TIME_BASE_MS = 8'h19;
    localparam logic [2:0] FAULTS_CODE0 = 3'h1;
    localparam logic [2:0] FAULTS_CODE1 = 3'h2;
    localparam logic [2:0] FAULTS_CODE2 = 3'h4;
    localparam logic [2:0] FAULTS_CODE3 = 3'h6;

    // Timing
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int NV_PROGRAM_TIME_US = 5000;
    localparam int NV_PROGRAM_CYCLES_DEF = (NV_PROGRAM_TIME_US * 1000) / CLOCK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_SKIP} link_state_t;

    typedef struct packed {
        logic [2:0] sclSync;
        logic [2:0] sdaSync;
        logic [2:0] rstSync;
        logic [8:0] addrSync;
        logic sclF;
        logic sdaF;
        logic rstF;
        logic [2:0] addrF;
        link_state_t st;
        logic [3:0] bitCnt;
        logic [7:0] shreg;
        logic [2:0] byteIdx;
        logic [7:0] hiByte;
        logic gotTwo;
        logic sdaOe;
        logic [15:0] nvStore;
        logic busy;
        logic [23:0] progCnt;
        logic [15:0] progData;
        logic loadPend;
        logic [1:0] resSel;
        logic [1:0] fqSel;
        logic pol;
        logic mode;
        logic sd;
        logic [3:0] resBits;
        logic [7:0] convMs;
        logic [2:0] faults;
    } state_t;
endpackage

// ---- nv_config_register_write_lock.sv ----
`timescale 1ns/1ns
module nv_config_register_write_lock
    import nv_config_pkg::*;
#(
    parameter int PROG_CYCLES = NV_PROGRAM_CYCLES_DEF
) (
    input wire logic clock, // System clock, 10 MHz
    input wire logic nrst, // Power-on reset, active low
    input wire logic sclIn, // Serial clock pin level
    input wire logic sdaIn, // Serial data pin level
    output logic sdaOut, // Serial data drive value
    output logic sdaOe, // Serial data drive enable
    input wire logic [2:0] addrSelectPins, // Address-select pin levels
    input wire logic deviceResetReq, // Device reset request pin
    output logic nvProgramBusyFlag, // Program cycle running
    output logic [1:0] cfgResolutionSel, // Working resolution code
    output logic [1:0] cfgFaultQueueSel, // Working fault-queue code
    output logic cfgAlarmPolarity, // Alarm active high when set
    output logic cfgAlarmModeSel, // Interrupt mode when set
    output logic cfgShutdown, // Shutdown mode when set
    output logic [3:0] resolutionBits, // Converter resolution in bits
    output logic [7:0] conversionTimeMs, // Conversion time in ms
    output logic [2:0] faultsRequired, // Consecutive faults before alarm
    output logic registersLocked, // Reversible lock or lockdown active
    output logic permanentLockdown, // Lockdown active
    output logic [15:0] nvConfigView // Stored value, reserved bits zero
);

    localparam logic [23:0] PROG_LAST = 24'(PROG_CYCLES - 1);

    state_t cur;
    state_t next_cur;

    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic addrMatch;
    logic rstRise;
    logic lockActive;
    logic lockdownActive;
    logic [15:0] newWord;
    logic [15:0] writeData;
    logic writeAllowed;

    // Bus events from filtered pin levels
    always_comb begin
        sclRise = 1'b0;
        sclFall = 1'b0;
        startSeen = 1'b0;
        stopSeen = 1'b0;
        if (cur.sclSync[1] == cur.sclSync[2]) begin
            sclRise = cur.sclSync[2] & ~cur.sclF;
            sclFall = ~cur.sclSync[2] & cur.sclF;
        end
        if (cur.sdaSync[1] == cur.sdaSync[2] && cur.sclF && !sclFall) begin
            startSeen = ~cur.sdaSync[2] & cur.sdaF;
            stopSeen = cur.sdaSync[2] & ~cur.sdaF;
        end
        rstRise = (cur.rstSync[1] == cur.rstSync[2]) & cur.rstSync[2] & ~cur.rstF;
    end

    // Address compare and write decision
    always_comb begin
        addrMatch = (cur.shreg[7:4] == ADDR_FIXED) && (cur.shreg[3:1] == cur.addrF)
            && !cur.shreg[0];
        lockActive = cur.nvStore[LOCK_BIT];
        lockdownActive = cur.nvStore[LOCKDOWN_BIT];
        newWord = {cur.hiByte, cur.shreg};
        writeData = (newWord & NV_WRITE_MASK) | (cur.nvStore & ~NV_WRITE_MASK);
        writeAllowed = 1'b0;
        if (cur.busy) begin
            writeAllowed = 1'b0;
        end else if (lockdownActive) begin
            writeAllowed = 1'b0;
        end else if (lockActive) begin
            // Only the lock bit may be cleared, everything else stays
            writeData = cur.nvStore;
            writeData[LOCK_BIT] = 1'b0;
            writeAllowed = !newWord[LOCK_BIT];
        end else begin
            writeAllowed = 1'b1;
        end
    end

    // Next-state logic
    always_comb begin
        next_cur = cur;

        // Three-stage pin synchronisers with agreement filter
        next_cur.sclSync = {cur.sclSync[1:0], sclIn};
        next_cur.sdaSync = {cur.sdaSync[1:0], sdaIn};
        next_cur.rstSync = {cur.rstSync[1:0], deviceResetReq};
        next_cur.addrSync = {cur.addrSync[5:0], addrSelectPins};
        if (cur.sclSync[1] == cur.sclSync[2]) begin
            next_cur.sclF = cur.sclSync[2];
        end
        if (cur.sdaSync[1] == cur.sdaSync[2]) begin
            next_cur.sdaF = cur.sdaSync[2];
        end
        if (cur.rstSync[1] == cur.rstSync[2]) begin
            next_cur.rstF = cur.rstSync[2];
        end
        if (cur.addrSync[5:3] == cur.addrSync[8:6]) begin
            next_cur.addrF = cur.addrSync[8:6];
        end

        // Serial receive engine
        if (startSeen) begin
            next_cur.st = ST_RX;
            next_cur.bitCnt = 4'h0;
            next_cur.byteIdx = BYTE_ADDR;
            next_cur.gotTwo = 1'b0;
            next_cur.sdaOe = 1'b0;
        end else if (stopSeen) begin
            next_cur.st = ST_IDLE;
            next_cur.gotTwo = 1'b0;
            next_cur.sdaOe = 1'b0;
            if (cur.gotTwo && writeAllowed) begin
                next_cur.busy = 1'b1;
                next_cur.progCnt = PROG_LAST;
                next_cur.progData = writeData;
            end
        end else begin
            unique case (cur.st)
                ST_IDLE: begin
                    next_cur.sdaOe = 1'b0;
                end
                ST_SKIP: begin
                    next_cur.sdaOe = 1'b0;
                end
                ST_RX: begin
                    if (sclRise && cur.bitCnt != BITS_PER_BYTE) begin
                        // Surplus bytes are counted but never overwrite the low data byte
                        if (cur.byteIdx != BYTE_EXTRA) begin
                            next_cur.shreg = {cur.shreg[6:0], cur.sdaF};
                        end
                        next_cur.bitCnt = cur.bitCnt + 4'h1;
                    end else if (sclFall && cur.bitCnt == BITS_PER_BYTE) begin
                        next_cur.st = ST_SKIP;
                        if (cur.byteIdx != BYTE_EXTRA) begin
                            next_cur.byteIdx = cur.byteIdx + 3'h1;
                        end
                        unique case (cur.byteIdx)
                            BYTE_ADDR: begin
                                if (addrMatch) begin
                                    next_cur.st = ST_ACK;
                                end
                            end
                            BYTE_PTR: begin
                                if (cur.shreg == PTR_NV_CONFIG) begin
                                    next_cur.st = ST_ACK;
                                end
                            end
                            BYTE_HI: begin
                                next_cur.hiByte = cur.shreg;
                                if (!cur.busy) begin
                                    next_cur.st = ST_ACK;
                                end
                            end
                            BYTE_LO: begin
                                if (!cur.busy) begin
                                    next_cur.st = ST_ACK;
                                    next_cur.gotTwo = 1'b1;
                                end
                            end
                            default: begin
                                // Surplus bytes acknowledged unless busy, and dropped
                                if (!cur.busy) begin
                                    next_cur.st = ST_ACK;
                                end
                            end
                        endcase
                        next_cur.sdaOe = (next_cur.st == ST_ACK);
                    end
                end
                ST_ACK: begin
                    // Hold the acknowledge low until the next serial clock falling edge
                    if (sclFall) begin
                        next_cur.sdaOe = 1'b0;
                        next_cur.st = ST_RX;
                        next_cur.bitCnt = 4'h0;
                    end
                end
            endcase
        end

        // Self-timed program cycle
        if (cur.busy) begin
            if (cur.progCnt == 24'h0) begin
                next_cur.busy = 1'b0;
                next_cur.nvStore = cur.progData;
            end else begin
                next_cur.progCnt = cur.progCnt - 24'h1;
            end
        end

        // Copy upper byte into the working configuration after reset
        next_cur.loadPend = 1'b0;
        if (cur.loadPend || rstRise) begin
            next_cur.resSel = cur.nvStore[RES_LSB +: 2];
            next_cur.fqSel = cur.nvStore[FQ_LSB +: 2];
            next_cur.pol = cur.nvStore[POL_BIT];
            next_cur.mode = cur.nvStore[MODE_BIT];
            next_cur.sd = cur.nvStore[SD_BIT];
            next_cur.resBits = RES_BITS_BASE + {2'b00, cur.nvStore[RES_LSB +: 2]};
            next_cur.convMs = CONV_TIME_BASE_MS << cur.nvStore[RES_LSB +: 2];
            unique case (cur.nvStore[FQ_LSB +: 2])
                2'h0: next_cur.faults = FAULTS_CODE0;
                2'h1: next_cur.faults = FAULTS_CODE1;
                2'h2: next_cur.faults = FAULTS_CODE2;
                2'h3: next_cur.faults = FAULTS_CODE3;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur <= '0;
            cur.sclSync <= 3'h7;
            cur.sdaSync <= 3'h7;
            cur.sclF <= 1'b1;
            cur.sdaF <= 1'b1;
            cur.st <= ST_IDLE;
            cur.nvStore <= NV_FACTORY;
            cur.loadPend <= 1'b1;
            cur.resBits <= RES_BITS_BASE;
            cur.convMs <= CONV_TIME_BASE_MS;
            cur.faults <= FAULTS_CODE0;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs
    assign sdaOut = 1'b0;
    assign sdaOe = cur.sdaOe;
    assign nvProgramBusyFlag = cur.busy;
    assign cfgResolutionSel = cur.resSel;
    assign cfgFaultQueueSel = cur.fqSel;
    assign cfgAlarmPolarity = cur.pol;
    assign cfgAlarmModeSel = cur.mode;
    assign cfgShutdown = cur.sd;
    assign resolutionBits = cur.resBits;
    assign conversionTimeMs = cur.convMs;
    assign faultsRequired = cur.faults;
    assign registersLocked = cur.nvStore[LOCK_BIT] | cur.nvStore[LOCKDOWN_BIT];
    assign permanentLockdown = cur.nvStore[LOCKDOWN_BIT];
    assign nvConfigView = cur.nvStore & NV_WRITE_MASK;
endmodule

// ---- nv_config_register_write_lock_bench.sv ----
`timescale 1ns/1ns
module nv_config_register_write_lock_bench;
    import nv_config_pkg::*;
    logic clock, nrst, sclM, sdaM, sdaOut, sdaOe, deviceResetReq, busy, pol, mode, sd;
    logic locked, lockdown, ackSeen, ackToggle;
    logic [2:0] addrSel, faults;
    logic [1:0] resSel, fqSel;
    logic [3:0] resBits;
    logic [7:0] convMs, hi, lo;
    logic [15:0] view, cur;
    logic [31:0] r;
    logic expAck[$];
    logic [15:0] expView[$];
    logic [2:0] faultTab [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    int seed = 83598;
    int errors = 0;
    int samplesChecked = 0;
    wire sdaWire = sdaM & (sdaOe ? sdaOut : 1'b1);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    nv_config_register_write_lock #(.PROG_CYCLES(2000)) i_dut (.clock(clock), .nrst(nrst),
        .sclIn(sclM), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrSelectPins(addrSel), .deviceResetReq(deviceResetReq), .nvProgramBusyFlag(busy),
        .cfgResolutionSel(resSel), .cfgFaultQueueSel(fqSel), .cfgAlarmPolarity(pol),
        .cfgAlarmModeSel(mode), .cfgShutdown(sd), .resolutionBits(resBits),
        .conversionTimeMs(convMs), .faultsRequired(faults), .registersLocked(locked),
        .permanentLockdown(lockdown), .nvConfigView(view));
    i2c_master_model i_master (.clock(clock), .sdaLine(sdaWire), .scl(sclM), .sda(sdaM),
        .ackSeen(ackSeen), .ackToggle(ackToggle));
    task automatic checkBit(input string what, input logic e, input logic g);
        samplesChecked++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic checkVal(input string what, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Acknowledges against the oldest expectation
    always @(ackToggle) begin
        if (expAck.size() > 0) begin
            checkBit("ack", expAck.pop_front(), ackSeen);
        end
    end
    // Store view once a program cycle ends
    always @(negedge busy) begin
        if (expView.size() > 0) begin
            #10;
            checkVal("view", expView.pop_front(), view);
        end
    end
    task automatic xfer(input logic [2:0] pins, input logic [7:0] ptr, input logic [15:0] d,
            input int n, input logic stop, input logic ackD);
        logic a;
        a = (pins == addrSel);
        expAck.push_back(a);
        i_master.startCond();
        i_master.sendByte({ADDR_FIXED, pins, 1'b0});
        expAck.push_back(a && ptr == PTR_NV_CONFIG);
        i_master.sendByte(ptr);
        for (int k = 0; k < n; k++) begin
            expAck.push_back(ackD);
            i_master.sendByte(k == 0 ? d[15:8] : (k == 1 ? d[7:0] : ~d[7:0]));
        end
        if (!stop) begin
            i_master.startCond();
        end
        i_master.stopCond();
    endtask
    task automatic waitIdle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
            @(posedge clock);
        end
        #20;
    endtask
    task automatic prog(input logic [15:0] d, input logic [15:0] e, input int n);
        xfer(addrSel, PTR_NV_CONFIG, d, n, 1'b1, 1'b1);
        expView.push_back(e);
        cur = e;
        repeat (10) @(posedge clock);
        checkBit("busy", 1'b1, busy);
        waitIdle();
    endtask
    task automatic refused(input logic [15:0] d, input int n, input logic stop);
        xfer(addrSel, PTR_NV_CONFIG, d, n, stop, 1'b1);
        repeat (60) @(posedge clock);
        checkBit("busy", 1'b0, busy);
        checkVal("view", cur, view);
    endtask
    task automatic checkCfg(input logic [7:0] h);
        @(posedge clock);
        #5;
        deviceResetReq = 1'b1;
        repeat (10) @(posedge clock);
        #5;
        deviceResetReq = 1'b0;
        repeat (10) @(posedge clock);
        checkVal("cfg", {9'h000, h[6:0]}, {9'h000, resSel, fqSel, pol, mode, sd});
        checkVal("resBits", {12'h000, RES_BITS_BASE + {2'h0, h[6:5]}}, {12'h000, resBits});
        checkVal("convMs", {8'h00, CONV_TIME_BASE_MS << h[6:5]}, {8'h00, convMs});
        checkVal("faults", {13'h0000, faultTab[h[4:3]]}, {13'h0000, faults});
    endtask
    // Main sequence
    initial begin
        nrst = 1'b0;
        deviceResetReq = 1'b0;
        addrSel = 3'($random(seed));
        repeat (2) @(posedge clock);
        #5;
        nrst = 1'b1;
        repeat (5) @(posedge clock);
        checkVal("view", 16'h0000, view);
        checkCfg(8'h00);
        cur = 16'h0000;
        $display("test factory done");
        xfer(~addrSel, PTR_NV_CONFIG, 16'h0000, 0, 1'b1, 1'b0);
        xfer(addrSel, 8'h12, 16'h0000, 0, 1'b1, 1'b0);
        $display("test address done");
        for (int c = 0; c < 4; c++) begin
            r = $random(seed);
            hi = {r[7], c[1:0], 2'(3 - c), r[2:0]};
            lo = r[15:8] & 8'hF9;
            prog({hi, lo}, {hi, lo} & NV_WRITE_MASK, 2 + c[0]);
            checkCfg(hi);
        end
        $display("test fields done");
        refused(16'h1200, 1, 1'b1);
        refused(16'h2300, 2, 1'b0);
        xfer(addrSel, PTR_NV_CONFIG, 16'h4B00, 2, 1'b1, 1'b1);
        expView.push_back(16'h4B00);
        cur = 16'h4B00;
        xfer(addrSel, PTR_NV_CONFIG, 16'h1100, 2, 1'b1, 1'b0);
        waitIdle();
        refused(16'h1100, 0, 1'b1);
        $display("test short and busy done");
        prog(16'h0002, 16'h0002, 2);
        refused(16'h3F02, 2, 1'b1);
        checkBit("locked", 1'b1, locked);
        prog(16'h3F00, 16'h0000, 2);
        prog(16'h0006, 16'h0006, 2);
        refused(16'h0000, 2, 1'b1);
        checkBit("lockdown", 1'b1, lockdown);
        $display("test locks done");
        final_report();
    end
    // Cuts a hang short
    initial begin
        repeat (80000) @(posedge clock);
        errors++;
        $display("ERROR watchdog expected end seen hang");
        final_report();
    end
endmodule
bind nv_config_register_write_lock nv_config_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_mon (.*);
